// *** hdl/fpsp_pkg.sv ***
// Constants shared by the flash program/status poller host.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.
package fpsp_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock and flash bus timing
  localparam int CLK_MHZ = 100;
  localparam int T_WP_NS = 50;     // Least write strobe low time
  localparam int T_WGAP_NS = 30;   // Least strobe high time between writes
  localparam int T_RD_NS = 120;    // Least read access time
  localparam int SYNC_DEPTH = 3;   // Flops on the data inputs
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WGAP_CYC = (T_WGAP_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_CYC = (T_RD_NS * CLK_MHZ + 999) / 1000 + SYNC_DEPTH;
  localparam logic [7:0] WP_CNT = 8'(WP_CYC - 1);
  localparam logic [7:0] WGAP_CNT = 8'(WGAP_CYC - 1);
  localparam logic [7:0] RD_CNT = 8'(RD_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Flash command words
  localparam logic [18:0] UNLOCK_ADDR1 = 19'h00555;
  localparam logic [18:0] UNLOCK_ADDR2 = 19'h002aa;
  localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] PROGRAM_CMD = 8'ha0;
  localparam logic [7:0] RESET_CMD = 8'hf0;
  localparam logic [1:0] PROG_LAST = 2'h3;  // Four writes in all
  localparam logic [1:0] RST_LAST = 2'h0;   // One write in all
  localparam int BIT_POLL = 7;              // data_poll_bit
  localparam int BIT_TOGGLE = 6;            // toggle_bit_one
  localparam int BIT_TIMING = 5;            // timing_exceeded_flag

  ////////////////////////////////////////////////////////////////////////
  // Register map, byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam int CTRL_PROG = 0;
  localparam int CTRL_RESET = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_TIMING = 3;
  localparam int ST_BYTE_LSB = 8;
  localparam logic [18:0] ADDR_RESET = 19'h00000;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_RD_LOW, ST_RD_HIGH
  } fpsp_state_t;

  typedef enum logic {OP_PROG, OP_RST} fpsp_op_t;

endpackage : fpsp_pkg

// *** hdl/fpsp_sync.sv ***
// Three-flop synchroniser for the flash data pins.
// Assumes inputs asynchronous to pclk; stable is high when the
// second and third flops agree.
`timescale 1ns/1ns
module fpsp_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout,
  output logic stable
);

  logic [W-1:0] s1_q, s2_q, s3_q;

  ////////////////////////////////////////////////////////////////////////
  // Chain; only s2 reads s1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign dout = s3_q;
  assign stable = (s2_q == s3_q);

endmodule : fpsp_sync

// *** hdl/fpsp_host.sv ***
// Host controller that programs one byte of a parallel flash and
// polls its write status. Software reaches it over APB.
// Assumes the flash pins are asynchronous to pclk and one flash.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns

// Behaviour
// - Two unlocks, program command, then data, four writes
// - Read twice, compare toggle bit for done
// - Still toggling: check timing flag, recheck, reset
// - Resumed polling restarts from first step
// - Write only with chip, write low, output high
module fpsp_host #(
  parameter int ADDR_W = 19
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash pins
  output logic [ADDR_W-1:0] fl_addr,
  output logic [7:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [7:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);

  fpsp_pkg::fpsp_state_t state_q, state_d;
  fpsp_pkg::fpsp_op_t op_q, op_d;
  logic [7:0] tmr_q, tmr_d;
  logic [1:0] idx_q, idx_d;
  logic rd2_q, rd2_d;         // Second read of a pair pending
  logic recheck_q, recheck_d; // Timing flag seen, one more pair
  logic [7:0] first_q, first_d;
  logic [7:0] byte_q, byte_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  logic done_q, done_d, fail_q, fail_d, tmo_q, tmo_d;
  logic [ADDR_W-1:0] pa_q, pa_d;
  logic [7:0] pd_q, pd_d;
  logic ce_q, ce_d, we_q, we_d, oe_q, oe_d, doe_q, doe_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pslverr_q, pslverr_d;
  logic [7:0] dq_s;
  logic dq_stable;
  logic wr_acc, setup;

  fpsp_sync #(.W(8)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(fl_dq_i),
    .dout(dq_s),
    .stable(dq_stable)
  );

  // Address and data of write idx of the current command
  function automatic logic [ADDR_W+7:0] cmd_word(
    input fpsp_pkg::fpsp_op_t op, input logic [1:0] idx,
    input logic [ADDR_W-1:0] ua, input logic [7:0] ud);
    logic [ADDR_W+7:0] w;
    w = {ua, fpsp_pkg::RESET_CMD};
    if (op == fpsp_pkg::OP_PROG) begin
      case (idx)
        2'h0: w = {ADDR_W'(fpsp_pkg::UNLOCK_ADDR1), fpsp_pkg::UNLOCK_DATA1};
        2'h1: w = {ADDR_W'(fpsp_pkg::UNLOCK_ADDR2), fpsp_pkg::UNLOCK_DATA2};
        2'h2: w = {ADDR_W'(fpsp_pkg::UNLOCK_ADDR1), fpsp_pkg::PROGRAM_CMD};
        default: w = {ua, ud};
      endcase
    end
    return w;
  endfunction : cmd_word

  ////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, so read data is set up in setup phase
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;

  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup) begin
      prdata_d = 32'h00000000;
      pslverr_d = 1'b0;
      case (paddr)
        fpsp_pkg::OFS_CTRL: prdata_d = 32'h00000000;
        fpsp_pkg::OFS_ADDR: prdata_d = 32'(addr_q);
        fpsp_pkg::OFS_DATA: prdata_d = 32'(data_q);
        fpsp_pkg::OFS_STATUS: begin
          prdata_d[fpsp_pkg::ST_BUSY] = (state_q != fpsp_pkg::ST_IDLE);
          prdata_d[fpsp_pkg::ST_DONE] = done_q;
          prdata_d[fpsp_pkg::ST_FAIL] = fail_q;
          prdata_d[fpsp_pkg::ST_TIMING] = tmo_q;
          prdata_d[fpsp_pkg::ST_BYTE_LSB +: 8] = byte_q;
        end
        default: pslverr_d = 1'b1;  // Unmapped offset
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: writes, paired status reads and the decision after each
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    tmr_d = tmr_q;
    idx_d = idx_q;
    rd2_d = rd2_q;
    recheck_d = recheck_q;
    first_d = first_q;
    byte_d = byte_q;
    addr_d = addr_q;
    data_d = data_q;
    done_d = done_q;
    fail_d = fail_q;
    tmo_d = tmo_q;
    // Operands are locked while an operation runs
    if (wr_acc && state_q == fpsp_pkg::ST_IDLE) begin
      if (paddr == fpsp_pkg::OFS_ADDR) addr_d = pwdata[ADDR_W-1:0];
      if (paddr == fpsp_pkg::OFS_DATA) data_d = pwdata[7:0];
      if (paddr == fpsp_pkg::OFS_CTRL &&
          (pwdata[fpsp_pkg::CTRL_PROG] || pwdata[fpsp_pkg::CTRL_RESET])) begin
        op_d = pwdata[fpsp_pkg::CTRL_PROG] ? fpsp_pkg::OP_PROG
                                            : fpsp_pkg::OP_RST;
        state_d = fpsp_pkg::ST_WR_LOW;
        tmr_d = fpsp_pkg::WP_CNT;
        idx_d = 2'h0;
        rd2_d = 1'b0;
        recheck_d = 1'b0;
        done_d = 1'b0;
        fail_d = 1'b0;
        tmo_d = 1'b0;
      end
    end
    case (state_q)
      fpsp_pkg::ST_IDLE: ;
      fpsp_pkg::ST_WR_LOW: begin
        if (tmr_q == 8'h00) begin
          state_d = fpsp_pkg::ST_WR_HIGH;
          tmr_d = fpsp_pkg::WGAP_CNT;
        end else tmr_d = tmr_q - 8'h01;
      end
      fpsp_pkg::ST_WR_HIGH: begin
        if (tmr_q != 8'h00) tmr_d = tmr_q - 8'h01;
        else if (op_q == fpsp_pkg::OP_PROG &&
                 idx_q != fpsp_pkg::PROG_LAST) begin
          idx_d = idx_q + 2'h1;
          state_d = fpsp_pkg::ST_WR_LOW;
          tmr_d = fpsp_pkg::WP_CNT;
        end else if (op_q == fpsp_pkg::OP_PROG) begin
          state_d = fpsp_pkg::ST_RD_LOW;
          tmr_d = fpsp_pkg::RD_CNT;
        end else begin
          state_d = fpsp_pkg::ST_IDLE;
          done_d = ~fail_q;
        end
      end
      fpsp_pkg::ST_RD_LOW: begin
        if (tmr_q != 8'h00) tmr_d = tmr_q - 8'h01;
        else if (dq_stable) begin
          byte_d = dq_s;
          state_d = fpsp_pkg::ST_RD_HIGH;
          tmr_d = fpsp_pkg::WGAP_CNT;
        end
      end
      fpsp_pkg::ST_RD_HIGH: begin
        if (tmr_q != 8'h00) tmr_d = tmr_q - 8'h01;
        else begin
          state_d = fpsp_pkg::ST_RD_LOW;
          tmr_d = fpsp_pkg::RD_CNT;
          rd2_d = ~rd2_q;
          if (!rd2_q) first_d = byte_q;
          else if (first_q[fpsp_pkg::BIT_TOGGLE] ==
                   byte_q[fpsp_pkg::BIT_TOGGLE]) begin
            // Settled: the byte now holds the array data; fail if it is not the programmed data
            state_d = fpsp_pkg::ST_IDLE;
            done_d = 1'b1;
            fail_d = (byte_q != data_q);
          end else if (byte_q[fpsp_pkg::BIT_TIMING]) begin
            tmo_d = 1'b1;
            if (recheck_q) begin
              // Failed: leave the flash in read mode again
              fail_d = 1'b1;
              op_d = fpsp_pkg::OP_RST;
              idx_d = 2'h0;
              state_d = fpsp_pkg::ST_WR_LOW;
              tmr_d = fpsp_pkg::WP_CNT;
            end else recheck_d = 1'b1;
          end else recheck_d = 1'b0;
        end
      end
      default: state_d = fpsp_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive from next state; outputs come straight from flops
  always_comb begin
    {pa_d, pd_d} = cmd_word(op_d, idx_d, addr_d, data_d);
    ce_d = 1'b1;
    we_d = 1'b1;
    oe_d = 1'b1;
    doe_d = 1'b0;
    case (state_d)
      fpsp_pkg::ST_WR_LOW: begin
        ce_d = 1'b0;
        we_d = 1'b0;
        doe_d = 1'b1;
      end
      fpsp_pkg::ST_WR_HIGH: doe_d = 1'b1;  // Data hold past rising edge
      fpsp_pkg::ST_RD_LOW: begin
        ce_d = 1'b0;
        oe_d = 1'b0;
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= fpsp_pkg::ST_IDLE;
      op_q <= fpsp_pkg::OP_PROG;
      tmr_q <= 8'h00;
      idx_q <= 2'h0;
      rd2_q <= 1'b0;
      recheck_q <= 1'b0;
      first_q <= 8'h00;
      byte_q <= 8'h00;
      addr_q <= fpsp_pkg::ADDR_RESET;
      data_q <= fpsp_pkg::DATA_RESET;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      tmo_q <= 1'b0;
      pa_q <= '0;
      pd_q <= 8'h00;
      ce_q <= 1'b1;
      we_q <= 1'b1;
      oe_q <= 1'b1;
      doe_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      tmr_q <= tmr_d;
      idx_q <= idx_d;
      rd2_q <= rd2_d;
      recheck_q <= recheck_d;
      first_q <= first_d;
      byte_q <= byte_d;
      addr_q <= addr_d;
      data_q <= data_d;
      done_q <= done_d;
      fail_q <= fail_d;
      tmo_q <= tmo_d;
      pa_q <= pa_d;
      pd_q <= pd_d;
      ce_q <= ce_d;
      we_q <= we_d;
      oe_q <= oe_d;
      doe_q <= doe_d;
      prdata_q <= prdata_d;
      pready_q <= 1'b1;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fl_addr = pa_q;
  assign fl_dq_o = pd_q;
  assign fl_dq_oe = doe_q;
  assign fl_ce_n = ce_q;
  assign fl_we_n = we_q;
  assign fl_oe_n = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_third_write;
    state_q == fpsp_pkg::ST_WR_LOW && op_q == fpsp_pkg::OP_PROG &&
    idx_q == 2'h2;
  endsequence

  a_write_inhibit: assert property (
    !fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe)
    else $error("write strobe without chip enable or with output on");
  a_unlock_cmd: assert property (
    s_third_write |-> fl_dq_o == fpsp_pkg::PROGRAM_CMD &&
    fl_addr == fpsp_pkg::UNLOCK_ADDR1)
    else $error("third program write is not the program command");
  a_first_unlock: assert property (
    $rose(state_q == fpsp_pkg::ST_WR_LOW) && op_q == fpsp_pkg::OP_PROG &&
    idx_q == 2'h0 |-> fl_dq_o == fpsp_pkg::UNLOCK_DATA1)
    else $error("program does not open with first unlock");
  a_pair_done: assert property (
    $rose(done_q) && op_q == fpsp_pkg::OP_PROG |->
    $past(rd2_q) && first_q[fpsp_pkg::BIT_TOGGLE] ==
    byte_q[fpsp_pkg::BIT_TOGGLE])
    else $error("done without two matching toggle reads");
  a_fail_reset: assert property (
    $rose(fail_q) && state_q == fpsp_pkg::ST_WR_LOW |->
    op_q == fpsp_pkg::OP_RST ##[1:40] fl_dq_o == fpsp_pkg::RESET_CMD &&
    !fl_we_n)
    else $error("failed program not followed by reset command");
  a_restart_poll: assert property (
    state_q == fpsp_pkg::ST_RD_HIGH && tmr_q == 8'h00 && rd2_q &&
    first_q[fpsp_pkg::BIT_TOGGLE] != byte_q[fpsp_pkg::BIT_TOGGLE] &&
    !byte_q[fpsp_pkg::BIT_TIMING] |=> !rd2_q && !recheck_q &&
    state_q == fpsp_pkg::ST_RD_LOW)
    else $error("polling did not restart from first read");

endmodule : fpsp_host

// *** verification/fpsp_flash_model.sv ***
// Behavioural parallel flash that stands on the far side of the host.
// Assumes one host on the pins; no clock, acts on strobe edges only.
`timescale 1ns/1ns
module fpsp_flash_model (
  // Host-driven pins
  input wire logic [18:0] fl_addr,
  input wire logic [7:0] fl_dq_o,
  input wire logic fl_dq_oe,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  // Bench controls
  input wire logic [3:0] busy_reads,
  input wire logic [3:0] limit_reads,
  // Data toward host
  output logic [7:0] fl_dq_i,
  // Observation counters
  output int prog_count,
  output int reset_count,
  output int seq_err,
  output int bad_cycles,
  output int poll_reads
);
  logic [7:0] mem [int];
  logic [1:0] step;
  logic busy, locked, tog, tflag, wr_arm, rd_arm;
  logic [18:0] a_lat, p_addr;
  logic [7:0] p_data, drv, last;
  int nreads;
  wire wr_n = fl_ce_n | fl_we_n;
  wire rd_n = fl_ce_n | fl_oe_n;

  // Expected address and data of each command step
  function automatic logic [26:0] cmd_word(input logic [1:0] s);
    case (s)
      2'h0: cmd_word = {fpsp_pkg::UNLOCK_ADDR1, fpsp_pkg::UNLOCK_DATA1};
      2'h1: cmd_word = {fpsp_pkg::UNLOCK_ADDR2, fpsp_pkg::UNLOCK_DATA2};
      default: cmd_word = {fpsp_pkg::UNLOCK_ADDR1, fpsp_pkg::PROGRAM_CMD};
    endcase
  endfunction : cmd_word

  // Power-up straight into read mode
  initial begin
    step = 2'h0;
    busy = 1'b0;
    {locked, tog, tflag, wr_arm, rd_arm} = 5'h00;
    prog_count = 0;
    reset_count = 0;
    seq_err = 0;
    bad_cycles = 0;
    poll_reads = 0;
    nreads = 0;
    last = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Address taken at the later falling edge of the two strobes
  always @(negedge wr_n) begin
    a_lat = fl_addr;
    wr_arm = 1'b1;
    if (fl_oe_n !== 1'b1) bad_cycles++;
  end

  // Data at the earlier rising edge; arming skips the power-up edge
  always @(posedge wr_n) begin
    if (wr_arm && fl_oe_n === 1'b1) begin
      if (fl_dq_oe !== 1'b1) bad_cycles++;
      if (fl_dq_o == fpsp_pkg::RESET_CMD) begin
        step = 2'h0;
        {busy, locked, tflag} = 3'h0;
        reset_count++;
      end else if (busy) begin
        step = 2'h0;
      end else if (step == 2'h3) begin
        p_addr = a_lat;
        p_data = fl_dq_o;
        locked = mem.exists(a_lat) && mem[a_lat] != 8'hff;
        busy = 1'b1;
        nreads = 0;
        poll_reads = 0;
        prog_count++;
        step = 2'h0;
      end else if ({a_lat, fl_dq_o} == cmd_word(step)) begin
        step++;
      end else begin
        seq_err++;
        step = 2'h0;
      end
    end
    wr_arm = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Status while busy, array otherwise; blank cells read all ones
  always @* begin
    if (busy) drv = {~p_data[7], tog, tflag, 5'h00};
    else if (mem.exists(fl_addr)) drv = mem[fl_addr];
    else drv = 8'hff;
  end

  // Released pins show the inverse, so a stale byte never passes
  assign fl_dq_i = (rd_n === 1'b0) ? drv : ~last;

  always @(negedge rd_n) begin
    rd_arm = 1'b1;
    if (fl_dq_oe === 1'b1) bad_cycles++;
  end

  // Toggle flips as each read closes; a locked cell never finishes
  always @(posedge rd_n) begin
    if (rd_arm && fl_we_n === 1'b1) begin
      last = drv;
      poll_reads++;
      if (busy) begin
        tog = ~tog;
        nreads++;
        // Finish only between host read pairs; a pair split across the
        // end would show array bit 5 to the host as a timing flag
        if (!locked && nreads > int'(busy_reads) && nreads % 2 == 0) begin
          mem[p_addr] = (mem.exists(p_addr) ? mem[p_addr] : 8'hff) & p_data;
          busy = 1'b0;
        end
        if (locked && nreads >= int'(limit_reads)) tflag = 1'b1;
      end
    end
    rd_arm = 1'b0;
  end
endmodule : fpsp_flash_model

// *** verification/flash_program_status_poller_tb.sv ***
// Self-checking bench: APB master, flash model, expected-array model.
// Assumes the host answers with zero wait states as handed over.
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module flash_program_status_poller_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, fl_dq_o, fl_dq_i, d, old;
  logic [31:0] pwdata, prdata, rd, st;
  logic [18:0] fl_addr, a, a_prev;
  logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n;
  logic [3:0] busy_reads, limit_reads;
  logic [7:0] exp_mem [int];
  int prog_count, reset_count, seq_err, bad_cycles, poll_reads;
  int err_total, tests_run, cycles, seed, exp_prog, exp_rst;

  fpsp_host i_fpsp_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n));
  fpsp_flash_model i_fpsp_flash_model (.fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .busy_reads(busy_reads),
    .limit_reads(limit_reads), .fl_dq_i(fl_dq_i),
    .prog_count(prog_count), .reset_count(reset_count),
    .seq_err(seq_err), .bad_cycles(bad_cycles), .poll_reads(poll_reads));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 80000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Counts: compares=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd, output logic [31:0] rdat,
                     output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Poll status until the host reports idle, bounded
  task automatic wait_idle(output logic [31:0] s);
    int n;
    n = 0;
    apb(1'b0, fpsp_pkg::OFS_STATUS, 32'h0, s, e);
    while (s[fpsp_pkg::ST_BUSY] !== 1'b0 && n < 3000) begin
      apb(1'b0, fpsp_pkg::OFS_STATUS, 32'h0, s, e);
      n++;
    end
  endtask : wait_idle

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'he14cf231;
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    busy_reads = 4'h0;
    limit_reads = 4'h3;
    {err_total, tests_run, cycles, exp_prog, exp_rst} = '0;
    a_prev = 19'h00000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and an unmapped offset
    apb(1'b0, fpsp_pkg::OFS_ADDR, 32'h0, rd, e);
    `CHK(rd, 32'(fpsp_pkg::ADDR_RESET))
    apb(1'b0, fpsp_pkg::OFS_DATA, 32'h0, rd, e);
    `CHK(rd, 32'(fpsp_pkg::DATA_RESET))
    apb(1'b0, fpsp_pkg::OFS_STATUS, 32'h0, rd, e);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h10, 32'h0, rd, e);
    `CHK({e, rd}, {1'b1, 32'h0})
    // Programs, every third one onto a cell already written
    for (int i = 0; i < 8; i++) begin
      a = (i % 3 == 2) ? a_prev : 19'($random(seed));
      d = 8'($random(seed));
      busy_reads <= 4'($random(seed)) & 4'h7;
      apb(1'b1, fpsp_pkg::OFS_ADDR, 32'(a), rd, e);
      apb(1'b1, fpsp_pkg::OFS_DATA, 32'(d), rd, e);
      apb(1'b1, fpsp_pkg::OFS_CTRL, 32'h1, rd, e);
      apb(1'b0, fpsp_pkg::OFS_STATUS, 32'h0, rd, e);
      `CHK(rd[fpsp_pkg::ST_BUSY], 1'b1)
      // Orders while busy must be dropped
      apb(1'b1, fpsp_pkg::OFS_ADDR, ~32'(a), rd, e);
      apb(1'b1, fpsp_pkg::OFS_CTRL, 32'h1, rd, e);
      apb(1'b0, fpsp_pkg::OFS_ADDR, 32'h0, rd, e);
      `CHK(rd, 32'(a))
      wait_idle(st);
      old = exp_mem.exists(a) ? exp_mem[a] : 8'hff;
      exp_prog++;
      if (old == 8'hff) begin
        exp_mem[a] = old & d;
        `CHK({st[15:8], st[3:0]}, {d, 4'h2})
      end else begin
        exp_rst++;
        `CHK(st[3:0], 4'hc)
      end
      `CHK(poll_reads >= 2, 1'b1)
      a_prev = a;
    end
    // Software-ordered reset command
    apb(1'b1, fpsp_pkg::OFS_CTRL, 32'h2, rd, e);
    wait_idle(st);
    exp_rst++;
    `CHK(reset_count, exp_rst)
    `CHK(prog_count, exp_prog)
    `CHK(seq_err, 0)
    `CHK(bad_cycles, 0)
    end_of_test();
  end
endmodule : flash_program_status_poller_tb
